//--- design/cfg_link_if.sv
// Serial configuration link between controller and converter port
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
	logic sclk;
	logic serial_select_n;
	logic serial_in_line;
	logic serial_out_line;
	logic power_down_pin;

	modport device
	(
		input sclk,
		input serial_select_n,
		input serial_in_line,
		input power_down_pin,
		output serial_out_line
	);

	modport host
	(
		output sclk,
		output serial_select_n,
		output serial_in_line,
		output power_down_pin,
		input serial_out_line
	);
endinterface
`default_nettype wire

//--- design/cfg_port_device.sv
// Converter end of the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module cfg_port_device
(
	// Serial link
	cfg_link_if.device link,
	// System clock for the power-down pin
	input wire logic pclk,
	input wire logic presetn,
	// Power-down state, pclk domain
	output logic power_down,
	// Page and channel state, serial clock domain
	output logic [7:0] analog_page,
	output logic [15:0] link_page,
	output logic per_channel_en
);
	// Frame capture
	logic frame_rst_n;
	logic [4:0] bit_cnt_reg;
	logic [22:0] shift_reg;
	logic [15:0] hdr_reg;
	logic [7:0] out_reg;
	logic commit_wr;
	logic [7:0] wr_data;

	// Configuration registers
	logic [7:0] analog_page_reg;
	logic [7:0] link_low_reg;
	logic [7:0] link_high_reg;
	logic [7:0] per_channel_reg;

	// Storage behind the pages
	logic [7:0] analog_mem [0:1][0:cfg_port_pkg::MEM_DEPTH-1];
	logic [7:0] link_mem [0:1][0:cfg_port_pkg::LINK_PAGES-1][0:cfg_port_pkg::MEM_DEPTH-1];

	// Decode
	logic [15:0] hdr_key;
	logic [7:0] mem_addr;
	logic hit_analog_page;
	logic hit_link_low;
	logic hit_link_high;
	logic hit_per_channel;
	logic analog_reg_access;
	logic link_reg_access;
	logic analog_page_ok;
	logic analog_idx;
	logic link_page_ok;
	logic [1:0] link_idx;
	logic [7:0] rd_data;
	logic [1:0] ch_wr;

	// Power-down synchroniser
	logic pdn_meta_reg;
	logic pdn_sync_reg;

	// A rising select clears the frame at once: no sclk edge is needed
	assign frame_rst_n = presetn & ~link.serial_select_n;

	// Every step is edge driven, so sclk rate and duty do not matter
	always_ff @(posedge link.sclk or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			bit_cnt_reg <= 5'h00;
			shift_reg <= 23'h000000;
		end
		else
		begin
			if (bit_cnt_reg != 5'(cfg_port_pkg::FRAME_BITS))
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
			shift_reg <= {shift_reg[21:0], link.serial_in_line};
		end
	end

	// Header is frozen after the sixteenth bit
	always_ff @(posedge link.sclk or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			hdr_reg <= 16'h0000;
		else if (bit_cnt_reg == 5'(cfg_port_pkg::HDR_BITS - 1))
			hdr_reg <= {shift_reg[14:0], link.serial_in_line};
	end

	assign wr_data = {shift_reg[6:0], link.serial_in_line};

	// Only the 24th edge of an unbroken frame may write
	assign commit_wr = (bit_cnt_reg == 5'(cfg_port_pkg::FRAME_BITS - 1)) &
		~hdr_reg[cfg_port_pkg::RW_POS] & frame_rst_n;

	// Address decode; read and channel bits do not take part
	assign hdr_key = {1'b0, hdr_reg[cfg_port_pkg::BANK_POS], hdr_reg[cfg_port_pkg::PAGE_POS], 1'b0,
		hdr_reg[cfg_port_pkg::ADDR_BITS-1:0]};
	assign mem_addr = hdr_reg[7:0];
	assign hit_analog_page = (hdr_key == cfg_port_pkg::ANALOG_PAGE_SEL_ADDR);
	assign hit_link_low = (hdr_key == cfg_port_pkg::LINK_PAGE_LOW_ADDR);
	assign hit_link_high = (hdr_key == cfg_port_pkg::LINK_PAGE_HIGH_ADDR);
	assign hit_per_channel = (hdr_key == cfg_port_pkg::PER_CHANNEL_ADDR);
	assign analog_reg_access = ~hdr_reg[cfg_port_pkg::BANK_POS] & ~hit_analog_page;
	assign link_reg_access = hdr_reg[cfg_port_pkg::BANK_POS] & hdr_reg[cfg_port_pkg::PAGE_POS];

	// Page lookup from the stored selectors
	assign analog_page_ok = (analog_page_reg == cfg_port_pkg::PAGE_MASTER) |
		(analog_page_reg == cfg_port_pkg::PAGE_CONVERTER);
	assign analog_idx = (analog_page_reg == cfg_port_pkg::PAGE_CONVERTER);
	assign link_idx = (link_high_reg == cfg_port_pkg::PAGE_DIGITAL_LINK) ? 2'h1 :
		(link_high_reg == cfg_port_pkg::PAGE_ANALOG_LINK) ? 2'h2 : 2'h0;
	assign link_page_ok = (link_low_reg == cfg_port_pkg::LINK_LOW_CODE) &
		((link_high_reg == cfg_port_pkg::PAGE_MAIN_DIGITAL) |
		(link_high_reg == cfg_port_pkg::PAGE_DIGITAL_LINK) |
		(link_high_reg == cfg_port_pkg::PAGE_ANALOG_LINK));

	// Selectors survive frames; only reset restores them
	always_ff @(posedge link.sclk or negedge presetn)
	begin
		if (!presetn)
		begin
			analog_page_reg <= cfg_port_pkg::ANALOG_PAGE_RESET;
			link_low_reg <= cfg_port_pkg::LINK_PAGE_LOW_RESET;
			link_high_reg <= cfg_port_pkg::LINK_PAGE_HIGH_RESET;
			per_channel_reg <= cfg_port_pkg::PER_CHANNEL_RESET;
		end
		else if (commit_wr)
		begin
			if (hit_analog_page)
				analog_page_reg <= wr_data;
			if (hit_link_low)
				link_low_reg <= wr_data;
			if (hit_link_high)
				link_high_reg <= wr_data;
			if (hit_per_channel)
				per_channel_reg <= wr_data;
		end
	end

	// Analog bank storage, addressed through the current page
	always_ff @(posedge link.sclk)
	begin
		if (commit_wr & analog_reg_access & analog_page_ok)
			analog_mem[analog_idx][mem_addr] <= wr_data;
	end

	// Link bank storage per channel; broadcast unless per-channel mode is on
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gen_chan
			assign ch_wr[g] = commit_wr & link_reg_access & link_page_ok &
				(~per_channel_reg[0] | (hdr_reg[cfg_port_pkg::CH_POS] == 1'(g)));
			always_ff @(posedge link.sclk)
			begin
				if (ch_wr[g])
					link_mem[g][link_idx][mem_addr] <= wr_data;
			end
		end
	endgenerate

	// Read-back source; unselected pages read as zero
	always_comb
	begin
		rd_data = 8'h00;
		if (hit_analog_page)
			rd_data = analog_page_reg;
		else if (hit_link_low)
			rd_data = link_low_reg;
		else if (hit_link_high)
			rd_data = link_high_reg;
		else if (hit_per_channel)
			rd_data = per_channel_reg;
		else if (analog_reg_access & analog_page_ok)
			rd_data = analog_mem[analog_idx][mem_addr];
		else if (link_reg_access & link_page_ok)
			rd_data = link_mem[hdr_reg[cfg_port_pkg::CH_POS]][link_idx][mem_addr];
	end

	// Read data launched on falling edges; the host samples it at the end of the next high phase
	always_ff @(negedge link.sclk or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			out_reg <= 8'h00;
		else if ((bit_cnt_reg == 5'(cfg_port_pkg::HDR_BITS)) & hdr_reg[cfg_port_pkg::RW_POS])
			out_reg <= rd_data;
		else if (bit_cnt_reg > 5'(cfg_port_pkg::HDR_BITS))
			out_reg <= {out_reg[6:0], 1'b0};
	end

	assign link.serial_out_line = out_reg[7];

	// Power-down pin is asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pdn_meta_reg <= 1'b0;
			pdn_sync_reg <= 1'b0;
			power_down <= 1'b0;
		end
		else
		begin
			pdn_meta_reg <= link.power_down_pin;
			pdn_sync_reg <= pdn_meta_reg;
			power_down <= pdn_sync_reg;
		end
	end

	assign analog_page = analog_page_reg;
	assign link_page = {link_high_reg, link_low_reg};
	assign per_channel_en = per_channel_reg[0];
endmodule // cfg_port_device
`default_nettype wire

//--- design/cfg_port_host.sv
// Controller end: APB registers drive serial configuration frames
`timescale 1ns/1ps
`default_nettype none
module cfg_port_host
(
	// Serial link
	cfg_link_if.host link,
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef enum {IDLE, LEAD, HIGH, LOW, TRAIL, GAP} host_state_e;

	host_state_e state_reg;
	logic [23:0] frame_reg;
	logic [23:0] tx_reg;
	logic [7:0] rx_reg;
	logic [7:0] rdata_reg;
	logic [7:0] div_reg;
	logic [7:0] div_cnt_reg;
	logic [4:0] bit_reg;
	logic done_reg;
	logic pdn_reg;
	logic sclk_reg;
	logic sel_n_reg;
	logic miso_meta_reg;
	logic miso_sync_reg;

	logic wr_acc;
	logic hit_frame;
	logic hit_status;
	logic hit_rdata;
	logic hit_div;
	logic hit_pdn;
	logic mapped;
	logic busy;
	logic start;
	logic half_done;

	assign hit_frame = (paddr == cfg_port_pkg::CTRL_FRAME_OFS);
	assign hit_status = (paddr == cfg_port_pkg::CTRL_STATUS_OFS);
	assign hit_rdata = (paddr == cfg_port_pkg::CTRL_RDATA_OFS);
	assign hit_div = (paddr == cfg_port_pkg::CTRL_DIV_OFS);
	assign hit_pdn = (paddr == cfg_port_pkg::CTRL_PDN_OFS);
	assign mapped = hit_frame | hit_status | hit_rdata | hit_div | hit_pdn;
	assign wr_acc = psel & penable & pwrite & mapped;
	assign busy = (state_reg != IDLE);
	// A frame write while busy is dropped rather than queued
	assign start = wr_acc & hit_frame & ~busy;
	assign half_done = (div_cnt_reg == div_reg - 8'h01);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	assign prdata = hit_frame ? {8'h00, frame_reg} :
		hit_status ? {30'h00000000, done_reg, busy} :
		hit_rdata ? {24'h000000, rdata_reg} :
		hit_div ? {24'h000000, div_reg} :
		hit_pdn ? {31'h00000000, pdn_reg} : 32'h00000000;

	// Software registers; divider never drops below the 2 MHz limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frame_reg <= 24'h000000;
			div_reg <= cfg_port_pkg::DIV_RESET;
			pdn_reg <= 1'b0;
		end
		else if (wr_acc)
		begin
			if (start)
				frame_reg <= pwdata[23:0];
			if (hit_div)
				div_reg <= (pwdata[7:0] < cfg_port_pkg::DIV_RESET) ? cfg_port_pkg::DIV_RESET : pwdata[7:0];
			if (hit_pdn)
				pdn_reg <= pwdata[0];
		end
	end

	// Read data from the device is asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			miso_meta_reg <= 1'b0;
			miso_sync_reg <= 1'b0;
		end
		else
		begin
			miso_meta_reg <= link.serial_out_line;
			miso_sync_reg <= miso_meta_reg;
		end
	end

	// Serial engine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= IDLE;
			tx_reg <= 24'h000000;
			rx_reg <= 8'h00;
			rdata_reg <= 8'h00;
			div_cnt_reg <= 8'h00;
			bit_reg <= 5'h00;
			done_reg <= 1'b0;
			sclk_reg <= 1'b0;
			sel_n_reg <= 1'b1;
		end
		else
		begin
			div_cnt_reg <= (state_reg == IDLE || half_done) ? 8'h00 : div_cnt_reg + 8'h01;
			case (state_reg)
				IDLE:
				begin
					if (start)
					begin
						tx_reg <= pwdata[23:0];
						bit_reg <= 5'h00;
						done_reg <= 1'b0;
						sel_n_reg <= 1'b0;
						state_reg <= LEAD;
					end
				end
				LEAD, LOW:
				begin
					if (half_done)
					begin
						sclk_reg <= 1'b1;
						state_reg <= HIGH;
					end
				end
				HIGH:
				begin
					if (half_done)
					begin
						rx_reg <= {rx_reg[6:0], miso_sync_reg};
						sclk_reg <= 1'b0;
						if (bit_reg == 5'(cfg_port_pkg::FRAME_BITS - 1))
							state_reg <= TRAIL;
						else
						begin
							bit_reg <= bit_reg + 5'h01;
							tx_reg <= {tx_reg[22:0], 1'b0};
							state_reg <= LOW;
						end
					end
				end
				TRAIL:
				begin
					if (half_done)
					begin
						sel_n_reg <= 1'b1;
						state_reg <= GAP;
					end
				end
				GAP:
				begin
					if (half_done)
					begin
						rdata_reg <= rx_reg;
						done_reg <= 1'b1;
						state_reg <= IDLE;
					end
				end
				default:
					state_reg <= IDLE;
			endcase
		end
	end

	assign link.sclk = sclk_reg;
	assign link.serial_select_n = sel_n_reg;
	assign link.serial_in_line = tx_reg[23];
	assign link.power_down_pin = pdn_reg;
endmodule // cfg_port_host
`default_nettype wire

//--- design/cfg_port_pkg.sv
// Shared constants of the paged serial configuration port, both ends
package cfg_port_pkg;
	// Frame layout
	localparam int FRAME_BITS = 24;
	localparam int HDR_BITS = 16;
	localparam int DATA_BITS = 8;
	localparam int RW_POS = 15;
	localparam int BANK_POS = 14;
	localparam int PAGE_POS = 13;
	localparam int CH_POS = 12;
	localparam int ADDR_BITS = 12;
	localparam int MEM_DEPTH = 256;
	localparam int LINK_PAGES = 3;

	// Device registers, header form with read and channel bits masked off
	localparam logic [15:0] ANALOG_PAGE_SEL_ADDR = 16'h0011;
	localparam logic [15:0] LINK_PAGE_LOW_ADDR = 16'h4003;
	localparam logic [15:0] LINK_PAGE_HIGH_ADDR = 16'h4004;
	localparam logic [15:0] PER_CHANNEL_ADDR = 16'h4005;

	// Page codes
	localparam logic [7:0] PAGE_MASTER = 8'h80;
	localparam logic [7:0] PAGE_CONVERTER = 8'h0f;
	localparam logic [7:0] LINK_LOW_CODE = 8'h00;
	localparam logic [7:0] PAGE_MAIN_DIGITAL = 8'h68;
	localparam logic [7:0] PAGE_DIGITAL_LINK = 8'h69;
	localparam logic [7:0] PAGE_ANALOG_LINK = 8'h6a;

	// Reset values
	localparam logic [7:0] ANALOG_PAGE_RESET = 8'h80;
	localparam logic [7:0] LINK_PAGE_LOW_RESET = 8'h00;
	localparam logic [7:0] LINK_PAGE_HIGH_RESET = 8'h00;
	localparam logic [7:0] PER_CHANNEL_RESET = 8'h00;

	// Controller registers on APB
	localparam logic [11:0] CTRL_FRAME_OFS = 12'h000;
	localparam logic [11:0] CTRL_STATUS_OFS = 12'h004;
	localparam logic [11:0] CTRL_RDATA_OFS = 12'h008;
	localparam logic [11:0] CTRL_DIV_OFS = 12'h00c;
	localparam logic [11:0] CTRL_PDN_OFS = 12'h010;

	// Timing
	localparam int PCLK_NS = 20;
	localparam int SCLK_MAX_KHZ = 2000;
	localparam int SCLK_HALF_NS = 1000000 / (2 * SCLK_MAX_KHZ);
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
	localparam logic [7:0] DIV_RESET = 8'(SCLK_HALF_CYC);
endpackage

//--- verification/cfg_port_monitor.sv
// Concurrent checks on the serial configuration link
`timescale 1ns/1ps
`default_nettype none
module cfg_port_monitor
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic serial_in_line,
	input wire logic serial_out_line,
	input wire logic power_down_pin,
	// Device state
	input wire logic power_down
);
	logic sclk_reg;
	logic [4:0] rise_cnt_reg;
	logic [4:0] rise_cnt_next;
	wire sclk_rise;

	// Link clock comes from the pclk divider, so pclk oversamples it
	assign sclk_rise = sclk && !sclk_reg;
	assign rise_cnt_next = serial_select_n ? 5'h00 :
		((sclk_rise && rise_cnt_reg != 5'h1f) ? rise_cnt_reg + 5'h01 : rise_cnt_reg);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_reg <= 1'b0;
			rise_cnt_reg <= 5'h00;
		end
		else
		begin
			sclk_reg <= sclk;
			rise_cnt_reg <= rise_cnt_next;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_clk_high;
		sclk [*8];
	endsequence

	sequence s_clk_low;
		!sclk [*8];
	endsequence

	a_sclk_idle_low: assert property (serial_select_n |-> !sclk)
		else $error("serial clock moved outside a frame");
	a_high_phase_min: assert property ($rose(sclk) |-> s_clk_high)
		else $error("serial clock high phase too short");
	a_low_phase_min: assert property ($fell(sclk) |-> s_clk_low)
		else $error("serial clock low phase too short");
	a_select_setup: assert property ($fell(serial_select_n) |-> s_clk_low)
		else $error("select to clock setup too short");
	a_select_hold: assert property ($fell(sclk) |-> !serial_select_n [*8])
		else $error("clock to select hold too short");
	a_din_steady_high: assert property (sclk |-> $stable(serial_in_line))
		else $error("data in changed while clock high");
	a_frame_rise_count: assert property ($rose(serial_select_n) |-> rise_cnt_reg == 5'h18)
		else $error("frame did not carry 24 clock rises");
	a_out_idle_low: assert property (serial_select_n && $past(serial_select_n) |-> !serial_out_line)
		else $error("serial out active outside a frame");
	a_out_on_fall: assert property ($changed(serial_out_line) |-> $fell(sclk) || $rose(serial_select_n))
		else $error("serial out changed off the falling clock");
	a_out_data_phase: assert property (serial_out_line |-> rise_cnt_reg >= 5'h10)
		else $error("serial out active in the header phase");
	a_pdn_sync_delay: assert property ($changed(power_down_pin) |-> ##3 (power_down == $past(power_down_pin, 3)))
		else $error("power down did not follow its pin");
endmodule // cfg_port_monitor
`default_nettype wire

//--- verification/paged_spi_config_port_bench.sv
// Testbench: both ends of the configuration link under APB control
`timescale 1ns/1ps
`default_nettype none
module paged_spi_config_port_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, power_down, per_channel_en, err;
	logic [7:0] analog_page, page2;
	logic [15:0] link_page;
	logic [31:0] rd;
	logic [7:0] codes [3] = '{8'h68, 8'h69, 8'h6a};
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;

	cfg_link_if link();
	cfg_link_if link2();

	always #10 pclk = ~pclk;

	cfg_port_host i_cfg_port_host (.link(link), .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	cfg_port_device i_cfg_port_device (.link(link), .pclk(pclk), .presetn(presetn), .power_down(power_down),
		.analog_page(analog_page), .link_page(link_page), .per_channel_en(per_channel_en));
	// Second end faces a bench driver that breaks framing on purpose
	cfg_port_device i_cfg_port_device_2 (.link(link2), .pclk(pclk), .presetn(presetn), .power_down(),
		.analog_page(page2), .link_page(), .per_channel_en());
	cfg_port_monitor i_cfg_port_monitor (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
		.serial_select_n(link.serial_select_n), .serial_in_line(link.serial_in_line),
		.serial_out_line(link.serial_out_line), .power_down_pin(link.power_down_pin), .power_down(power_down));

	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task check_flag(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One whole frame, then the last shifted-in byte
	task frame(input logic [15:0] hdr, input logic [7:0] d);
		apb(1'b1, cfg_port_pkg::CTRL_FRAME_OFS, {8'h00, hdr, d});
		rd = 32'h1;
		while (rd[1:0] !== 2'b10)
			apb(1'b0, cfg_port_pkg::CTRL_STATUS_OFS, 32'h0);
		apb(1'b0, cfg_port_pkg::CTRL_RDATA_OFS, 32'h0);
	endtask

	// Bit-banged frame of n bits on the second link; sel high keeps the device deselected
	task bang(input logic [23:0] f, input int n, input logic sel);
		int i;
		@(posedge pclk);
		link2.serial_select_n <= sel;
		link2.serial_in_line <= f[23];
		for (i = 0; i < n; i++)
		begin
			repeat (13) @(posedge pclk);
			link2.sclk <= 1'b1;
			repeat (13) @(posedge pclk);
			link2.sclk <= 1'b0;
			f = f << 1;
			link2.serial_in_line <= f[23];
		end
		repeat (13) @(posedge pclk);
		link2.serial_select_n <= 1'b1;
		link2.serial_in_line <= ~f[23];
		repeat (13) @(posedge pclk);
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			report_and_stop;
		end
	end

	initial
	begin
		// Reset falls at time zero, after its initial high, so sclk-domain resets see an edge
		presetn <= 1'b0;
		link2.sclk = 1'b0;
		link2.serial_select_n = 1'b1;
		link2.serial_in_line = 1'b0;
		link2.power_down_pin = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check_val("analog page", 32'h80, {24'h0, analog_page});
		check_val("link page", 32'h0, {16'h0, link_page});
		check_flag("per channel", 1'b0, per_channel_en);
		apb(1'b0, cfg_port_pkg::CTRL_DIV_OFS, 32'h0);
		check_val("divider", {24'h0, cfg_port_pkg::DIV_RESET}, rd);
		apb(1'b1, cfg_port_pkg::CTRL_DIV_OFS, 32'h5);
		apb(1'b0, cfg_port_pkg::CTRL_DIV_OFS, 32'h0);
		check_val("divider floor", {24'h0, cfg_port_pkg::DIV_RESET}, rd);
		apb(1'b0, 12'h020, 32'h0);
		check_flag("unmapped error", 1'b1, err);
		check_val("unmapped data", 32'h0, rd);
		$display("reset test done");
		frame(16'h0011, 8'h0f);
		check_val("analog page", 32'h0f, {24'h0, analog_page});
		frame(16'h0020, 8'ha5);
		frame(16'h0011, 8'h80);
		check_val("analog page", 32'h80, {24'h0, analog_page});
		frame(16'h0020, 8'h5a);
		frame(16'h8020, 8'h00);
		check_val("master read", 32'h5a, {24'h0, rd[7:0]});
		frame(16'h0011, 8'h0f);
		frame(16'h8020, 8'h00);
		check_val("converter read", 32'ha5, {24'h0, rd[7:0]});
		frame(16'h8011, 8'h00);
		check_val("page read", 32'h0f, {24'h0, rd[7:0]});
		apb(1'b0, cfg_port_pkg::CTRL_FRAME_OFS, 32'h0);
		check_val("frame register", 32'h00801100, rd);
		$display("analog bank test done");
		frame(16'h4003, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			frame(16'h4004, codes[k]);
			check_val("link page", {16'h0, codes[k], 8'h00}, {16'h0, link_page});
			frame(16'h6010, codes[k] ^ 8'h11);
			frame(16'he010, 8'h00);
			check_val("channel a", {24'h0, codes[k] ^ 8'h11}, {24'h0, rd[7:0]});
			frame(16'hf010, 8'h00);
			check_val("channel b", {24'h0, codes[k] ^ 8'h11}, {24'h0, rd[7:0]});
		end
		frame(16'h4005, 8'h01);
		check_flag("per channel", 1'b1, per_channel_en);
		frame(16'h7010, 8'h33);
		frame(16'he010, 8'h00);
		check_val("channel a kept", 32'h7b, {24'h0, rd[7:0]});
		frame(16'hf010, 8'h00);
		check_val("channel b", 32'h33, {24'h0, rd[7:0]});
		$display("link bank test done");
		apb(1'b1, cfg_port_pkg::CTRL_PDN_OFS, 32'h1);
		repeat (5) @(posedge pclk);
		check_flag("power pin", 1'b1, link.power_down_pin);
		check_flag("power down", 1'b1, power_down);
		apb(1'b1, cfg_port_pkg::CTRL_PDN_OFS, 32'h0);
		repeat (5) @(posedge pclk);
		check_flag("power down", 1'b0, power_down);
		$display("power down test done");
		bang(24'h00110f, 23, 1'b0);
		check_val("short frame", 32'h80, {24'h0, page2});
		bang(24'h00110f, 24, 1'b1);
		check_val("deselected", 32'h80, {24'h0, page2});
		bang(24'h00110f, 24, 1'b0);
		check_val("full frame", 32'h0f, {24'h0, page2});
		$display("framing test done");
		report_and_stop;
	end
endmodule // paged_spi_config_port_bench
`default_nettype wire
